// ==== op_timer.sv ====
// Down-counting duration timer for one extended memory operation
`timescale 1ns/1ps
module op_timer (
  // Clock and reset
  input  wire logic                                sys_clk_in,
  input  wire logic                                reset_in,
  // Control
  input  wire logic                                start_in,
  input  wire logic [serial_ext_pkg::TIMER_W-1:0]  count_in,
  // Status
  output logic                                     busy_out,
  output logic                                     expired_out
);

  logic [serial_ext_pkg::TIMER_W-1:0] count_q;

  // Load on start, then count down to zero
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      count_q <= '0;
    end else if (start_in) begin
      count_q <= count_in;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Expiry marks the last cycle of the run
  assign busy_out    = (count_q != '0);
  assign expired_out = (count_q == {{(serial_ext_pkg::TIMER_W-1){1'b0}}, 1'b1});

endmodule

// ==== serial_ext_far_model.sv ====
// Far-side model: memory array and coded action engine
`timescale 1ns/1ps
module serial_ext_far_model (
  // Clock
  input  wire logic        sys_clk_in,
  // Memory side
  input  wire logic        mem_write_req_in,
  input  wire logic [7:0]  mem_write_addr_in,
  input  wire logic [31:0] mem_write_data_in,
  input  wire logic [7:0]  mem_read_addr_in,
  output logic      [31:0] mem_read_data_out,
  // Action side
  input  wire logic        action_start_in,
  output logic             action_complete_out = 1'b0
);
  logic [31:0] mem_q [256];
  always @(posedge sys_clk_in) begin
    if (mem_write_req_in)
      mem_q[mem_write_addr_in] <= mem_write_data_in;
  end
  assign mem_read_data_out = mem_q[mem_read_addr_in];
  // Action finishes eight cycles after its start pulse
  always @(posedge sys_clk_in) begin
    if (action_start_in) begin
      repeat (8) @(negedge sys_clk_in);
      action_complete_out <= 1'b1;
      @(negedge sys_clk_in);
      action_complete_out <= 1'b0;
    end
  end
endmodule

// ==== serial_ext_pkg.sv ====
// Constants for the extended access and device control register bank
package serial_ext_pkg;

  // Clock and operation timing
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned NVM_WRITE_TIME_US  = 24000;
  localparam int unsigned NVM_READ_TIME_NS   = 2000;
  localparam int unsigned NVM_WRITE_CYCLES   = NVM_WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned NVM_READ_CYCLES    = (NVM_READ_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned SHADOW_CYCLES      = 1;
  localparam int unsigned TIMER_W            = 23;

  // Register byte offsets (most significant byte of each word)
  localparam logic [7:0] OFS_EXT_WRITE_ADDRESS        = 8'h02;
  localparam logic [7:0] OFS_EXT_WRITE_DATA_HIGH      = 8'h04;
  localparam logic [7:0] OFS_EXT_WRITE_DATA_LOW       = 8'h06;
  localparam logic [7:0] OFS_EXT_WRITE_CONTROL_STATUS = 8'h08;
  localparam logic [7:0] OFS_EXT_READ_ADDRESS         = 8'h0A;
  localparam logic [7:0] OFS_EXT_READ_CONTROL_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_EXT_READ_DATA_HIGH       = 8'h0E;
  localparam logic [7:0] OFS_EXT_READ_DATA_LOW        = 8'h10;
  localparam logic [7:0] OFS_DEVICE_CONTROL           = 8'h1E;

  // Field positions
  localparam int unsigned START_BIT       = 15;
  localparam int unsigned IN_PROGRESS_BIT = 8;
  localparam int unsigned DONE_BIT        = 0;
  localparam int unsigned ACTION_MSB      = 15;
  localparam int unsigned ACTION_LSB      = 12;
  localparam int unsigned OVERRIDE_BIT    = 11;
  localparam int unsigned STATUS_CLR_BIT  = 10;
  localparam int unsigned WARN_CLR_BIT    = 9;
  localparam int unsigned ERROR_CLR_BIT   = 8;
  localparam int unsigned TRIGGER_MSB     = 7;

  // Address ranges
  localparam logic [7:0] WR_NVM_LO    = 8'h17;
  localparam logic [7:0] WR_NVM_HI    = 8'h2F;
  localparam logic [7:0] WR_SHADOW_LO = 8'h58;
  localparam logic [7:0] WR_SHADOW_HI = 8'h6F;
  localparam logic [7:0] RD_NVM_LO    = 8'h00;
  localparam logic [7:0] RD_NVM_HI    = 8'h1F;
  localparam logic [7:0] RD_SHADOW_LO = 8'h40;
  localparam logic [7:0] RD_SHADOW_HI = 8'h5F;

  // Action codes
  localparam logic [3:0] ACT_NONE        = 4'h0;
  localparam logic [3:0] ACT_MARGIN_LOW  = 4'h1;
  localparam logic [3:0] ACT_MARGIN_HIGH = 4'h2;
  localparam logic [3:0] ACT_TURNS_LOAD  = 4'h3;
  localparam logic [3:0] ACT_TURNS_RESET = 4'h4;
  localparam logic [3:0] ACT_NVM_RELOAD  = 4'h5;
  localparam logic [3:0] ACT_HARD_RESET  = 4'h7;
  localparam logic [3:0] ACT_TEST_SENSOR = 4'h9;
  localparam logic [3:0] ACT_TEST_LOGIC  = 4'hA;
  localparam logic [3:0] ACT_TEST_BOTH   = 4'hB;
  localparam logic [3:0] ACT_FORCE_FAULT = 4'hC;
  localparam logic [3:0] ACT_PW_RESAMPLE = 4'hD;
  localparam logic [3:0] ACT_PW_CLEAR    = 4'hE;
  localparam logic [3:0] ACT_PW_BOTH     = 4'hF;

  // Key bytes
  localparam logic [7:0] KEY_TURNS  = 8'h46;
  localparam logic [7:0] KEY_RELOAD = 8'hA5;
  localparam logic [7:0] KEY_RESET  = 8'h5A;
  localparam logic [7:0] KEY_TEST   = 8'hB9;
  localparam logic [7:0] KEY_FORCE  = 8'h67;

  // Action sequencer states
  typedef enum logic [0:0] {
    ACT_IDLE = 1'b0,
    ACT_BUSY = 1'b1
  } action_state_type;

endpackage

// ==== serial_ext_regs.sv ====
// Extended write/read access and device control register bank
//
// Summary of operation
// R1 - Write address selects nonvolatile or shadow target
// R2 - Host loads both write data halves first
// R3 - Write start launches write, sets busy flag
// R4 - Write busy at bit 8, done at 0
// R5 - Read address selects nonvolatile or shadow source
// R6 - Read start launches read, sets busy flag
// R7 - Read busy at bit 8, done at 0
// R8 - Read result halves valid once done set
// R9 - Action field clears on completion except margining
// R10 - Margin codes honoured only while unlocked
// R11 - Turns load and reset need key 0x46
// R12 - Reload needs unlock and key 0xA5
// R13 - Hard reset needs unlock and key 0x5A
// R14 - Self-test codes need key 0xB9
// R15 - Fault forcing uses write data, key 0x67
// R16 - Pulse-width resample and clear codes
// R17 - Override bit forces serial output on MISO
// R18 - Status clear drops action and boot done
// R19 - Warning clear pulses, reads as zero
// R20 - Error clear pulses, reads as zero
// R21 - Trigger byte write-only, written after code
// R22 - Action done drops on trigger, rises after
// R23 - Start ignored while same operation running
`timescale 1ns/1ps
module serial_ext_regs #(
  parameter int unsigned WRITE_CYCLES = serial_ext_pkg::NVM_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  // Memory access
  output logic             mem_write_req_out,
  output logic      [7:0]  mem_write_addr_out,
  output logic      [31:0] mem_write_data_out,
  output logic             mem_read_req_out,
  output logic      [7:0]  mem_read_addr_out,
  input  wire logic [31:0] mem_read_data_in,
  // Device actions
  input  wire logic        unlocked_in,
  input  wire logic        action_complete_in,
  input  wire logic        boot_complete_in,
  output logic             action_start_out,
  output logic      [3:0]  action_code_out,
  output logic             margin_low_out,
  output logic             margin_high_out,
  output logic             serial_output_override_out,
  output logic             action_done_flag_out,
  output logic             boot_done_flag_out,
  output logic             warning_clear_out,
  output logic             error_clear_out
);

  // ----------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------

  logic [7:0]  write_addr_q;
  logic [15:0] write_word_upper_q;
  logic [15:0] write_word_lower_q;
  logic [7:0]  read_addr_q;
  logic [15:0] read_word_upper_q;
  logic [15:0] read_word_lower_q;
  logic        write_in_progress_flag_q;
  logic        write_done_flag_q;
  logic        read_in_progress_flag_q;
  logic        read_done_flag_q;
  logic [3:0]  action_select_q;
  logic        action_done_flag_q;
  logic        boot_done_flag_q;
  logic [15:0] rdata_q;
  serial_ext_pkg::action_state_type act_state_q;

  logic        wr_ctrl;
  logic        write_start;
  logic        read_start;
  logic        action_trigger;
  logic        write_expired;
  logic        read_expired;
  logic [3:0]  new_code;
  logic [7:0]  new_key;

  // Inclusive range test used for both address maps
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Key byte that arms each keyed code, zero for unkeyed codes
  function automatic logic [7:0] key_for(input logic [3:0] code);
    case (code)
      serial_ext_pkg::ACT_TURNS_LOAD,
      serial_ext_pkg::ACT_TURNS_RESET: key_for = serial_ext_pkg::KEY_TURNS;
      serial_ext_pkg::ACT_NVM_RELOAD:  key_for = serial_ext_pkg::KEY_RELOAD;
      serial_ext_pkg::ACT_HARD_RESET:  key_for = serial_ext_pkg::KEY_RESET;
      serial_ext_pkg::ACT_TEST_SENSOR,
      serial_ext_pkg::ACT_TEST_LOGIC,
      serial_ext_pkg::ACT_TEST_BOTH:   key_for = serial_ext_pkg::KEY_TEST;
      serial_ext_pkg::ACT_FORCE_FAULT: key_for = serial_ext_pkg::KEY_FORCE;
      default:                         key_for = 8'h00;
    endcase
  endfunction

  // Whether a control write with this code and byte starts an action
  function automatic logic trigger_ok(input logic [3:0] code, input logic [7:0] key,
                                      input logic unlocked);
    case (code)
      // R12 unlock plus key
      serial_ext_pkg::ACT_NVM_RELOAD,
      serial_ext_pkg::ACT_HARD_RESET:  trigger_ok = unlocked && (key == key_for(code));
      // R16 no key byte needed
      serial_ext_pkg::ACT_PW_RESAMPLE,
      serial_ext_pkg::ACT_PW_CLEAR,
      serial_ext_pkg::ACT_PW_BOTH:     trigger_ok = 1'b1;
      serial_ext_pkg::ACT_NONE,
      serial_ext_pkg::ACT_MARGIN_LOW,
      serial_ext_pkg::ACT_MARGIN_HIGH: trigger_ok = 1'b0;
      default:                         trigger_ok = (key_for(code) != 8'h00) &&
                                                    (key == key_for(code));
    endcase
  endfunction

  // Write strobes decoded from the byte offset
  assign wr_ctrl  = reg_wr_in && (reg_addr_in == serial_ext_pkg::OFS_DEVICE_CONTROL);
  assign new_code = reg_wdata_in[serial_ext_pkg::ACTION_MSB:serial_ext_pkg::ACTION_LSB];
  assign new_key  = reg_wdata_in[serial_ext_pkg::TRIGGER_MSB:0];
  // R23 start ignored while busy
  assign write_start = reg_wr_in && reg_wdata_in[serial_ext_pkg::START_BIT] &&
                       (reg_addr_in == serial_ext_pkg::OFS_EXT_WRITE_CONTROL_STATUS) &&
                       !write_in_progress_flag_q;
  assign read_start  = reg_wr_in && reg_wdata_in[serial_ext_pkg::START_BIT] &&
                       (reg_addr_in == serial_ext_pkg::OFS_EXT_READ_CONTROL_STATUS) &&
                       !read_in_progress_flag_q;
  // R21 trigger byte after code
  assign action_trigger = wr_ctrl && (act_state_q == serial_ext_pkg::ACT_IDLE) &&
                          trigger_ok(new_code, new_key, unlocked_in);

  // ----------------------------------------------------------------
  // Writable address and data registers
  // ----------------------------------------------------------------

  // R1 address and R2 data halves
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      write_addr_q       <= 8'h00;
      write_word_upper_q <= 16'h0000;
      write_word_lower_q <= 16'h0000;
      read_addr_q        <= 8'h00;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        serial_ext_pkg::OFS_EXT_WRITE_ADDRESS:   write_addr_q       <= reg_wdata_in[7:0];
        serial_ext_pkg::OFS_EXT_WRITE_DATA_HIGH: write_word_upper_q <= reg_wdata_in;
        serial_ext_pkg::OFS_EXT_WRITE_DATA_LOW:  write_word_lower_q <= reg_wdata_in;
        serial_ext_pkg::OFS_EXT_READ_ADDRESS:    read_addr_q        <= reg_wdata_in[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Extended write and read sequencing
  // ----------------------------------------------------------------

  op_timer u_write_timer (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .start_in    (write_start),
    .count_in    (in_range(write_addr_q, serial_ext_pkg::WR_NVM_LO, serial_ext_pkg::WR_NVM_HI)
                  ? serial_ext_pkg::TIMER_W'(WRITE_CYCLES)
                  : serial_ext_pkg::TIMER_W'(serial_ext_pkg::SHADOW_CYCLES)),
    .busy_out    (),
    .expired_out (write_expired)
  );

  // R5 read source range sets fetch time
  op_timer u_read_timer (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .start_in    (read_start),
    .count_in    (in_range(read_addr_q, serial_ext_pkg::RD_NVM_LO, serial_ext_pkg::RD_NVM_HI)
                  ? serial_ext_pkg::TIMER_W'(serial_ext_pkg::NVM_READ_CYCLES)
                  : serial_ext_pkg::TIMER_W'(serial_ext_pkg::SHADOW_CYCLES)),
    .busy_out    (),
    .expired_out (read_expired)
  );

  // R3 R4 write flags
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      write_in_progress_flag_q <= 1'b0;
      write_done_flag_q        <= 1'b0;
    end else if (write_start) begin
      write_in_progress_flag_q <= 1'b1;
      write_done_flag_q        <= 1'b0;
    end else if (write_expired && write_in_progress_flag_q) begin
      write_in_progress_flag_q <= 1'b0;
      write_done_flag_q        <= 1'b1;
    end
  end

  // R6 R7 R8 read flags and result capture
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      read_in_progress_flag_q <= 1'b0;
      read_done_flag_q        <= 1'b0;
      read_word_upper_q       <= 16'h0000;
      read_word_lower_q       <= 16'h0000;
    end else if (read_start) begin
      read_in_progress_flag_q <= 1'b1;
      read_done_flag_q        <= 1'b0;
    end else if (read_expired && read_in_progress_flag_q) begin
      read_in_progress_flag_q <= 1'b0;
      read_done_flag_q        <= 1'b1;
      read_word_upper_q       <= mem_read_data_in[31:16];
      read_word_lower_q       <= mem_read_data_in[15:0];
    end
  end

  // Memory requests issued one cycle after an accepted start
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mem_write_req_out <= 1'b0;
      mem_read_req_out  <= 1'b0;
    end else begin
      mem_write_req_out <= write_start;
      mem_read_req_out  <= read_start;
    end
  end

  assign mem_write_addr_out = write_addr_q;
  assign mem_write_data_out = {write_word_upper_q, write_word_lower_q};
  assign mem_read_addr_out  = read_addr_q;

  // ----------------------------------------------------------------
  // Device control and coded actions
  // ----------------------------------------------------------------

  // R9 field held until completion
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      action_select_q <= serial_ext_pkg::ACT_NONE;
      act_state_q     <= serial_ext_pkg::ACT_IDLE;
    end else begin
      case (act_state_q)
        serial_ext_pkg::ACT_IDLE: begin
          if (wr_ctrl) begin
            action_select_q <= new_code;
          end
          if (action_trigger) begin
            act_state_q <= serial_ext_pkg::ACT_BUSY;
          end
        end
        serial_ext_pkg::ACT_BUSY: begin
          if (action_complete_in) begin
            action_select_q <= serial_ext_pkg::ACT_NONE;
            act_state_q     <= serial_ext_pkg::ACT_IDLE;
          end
        end
        default: act_state_q <= serial_ext_pkg::ACT_IDLE;
      endcase
    end
  end

  // R11 R13 R14 R15 launch pulse
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      action_start_out <= 1'b0;
      action_code_out  <= 4'h0;
    end else begin
      action_start_out <= action_trigger;
      if (action_trigger) begin
        action_code_out <= new_code;
      end
    end
  end

  // R10 margin modes need unlock
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      margin_low_out  <= 1'b0;
      margin_high_out <= 1'b0;
    end else begin
      margin_low_out  <= unlocked_in && (action_select_q == serial_ext_pkg::ACT_MARGIN_LOW);
      margin_high_out <= unlocked_in && (action_select_q == serial_ext_pkg::ACT_MARGIN_HIGH);
    end
  end

  // R17 serial output override
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      serial_output_override_out <= 1'b0;
    end else if (wr_ctrl) begin
      serial_output_override_out <= reg_wdata_in[serial_ext_pkg::OVERRIDE_BIT];
    end
  end

  // R22 R18 done flags, set beats clear
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      action_done_flag_q <= 1'b0;
      boot_done_flag_q   <= 1'b0;
    end else begin
      if (act_state_q == serial_ext_pkg::ACT_BUSY && action_complete_in) begin
        action_done_flag_q <= 1'b1;
      end else if (action_trigger) begin
        action_done_flag_q <= 1'b0;
      end else if (wr_ctrl && reg_wdata_in[serial_ext_pkg::STATUS_CLR_BIT]) begin
        action_done_flag_q <= 1'b0;
      end
      if (boot_complete_in) begin
        boot_done_flag_q <= 1'b1;
      end else if (wr_ctrl && reg_wdata_in[serial_ext_pkg::STATUS_CLR_BIT]) begin
        boot_done_flag_q <= 1'b0;
      end
    end
  end

  assign action_done_flag_out = action_done_flag_q;
  assign boot_done_flag_out   = boot_done_flag_q;

  // R19 R20 clear pulses to flag registers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      warning_clear_out <= 1'b0;
      error_clear_out   <= 1'b0;
    end else begin
      warning_clear_out <= wr_ctrl && reg_wdata_in[serial_ext_pkg::WARN_CLR_BIT];
      error_clear_out   <= wr_ctrl && reg_wdata_in[serial_ext_pkg::ERROR_CLR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------

  // Start, clear and trigger bits always return zero
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        serial_ext_pkg::OFS_EXT_WRITE_ADDRESS:        rdata_q <= {8'h00, write_addr_q};
        serial_ext_pkg::OFS_EXT_WRITE_DATA_HIGH:      rdata_q <= write_word_upper_q;
        serial_ext_pkg::OFS_EXT_WRITE_DATA_LOW:       rdata_q <= write_word_lower_q;
        serial_ext_pkg::OFS_EXT_WRITE_CONTROL_STATUS:
          rdata_q <= {7'h00, write_in_progress_flag_q, 7'h00, write_done_flag_q};
        serial_ext_pkg::OFS_EXT_READ_ADDRESS:         rdata_q <= {8'h00, read_addr_q};
        serial_ext_pkg::OFS_EXT_READ_CONTROL_STATUS:
          rdata_q <= {7'h00, read_in_progress_flag_q, 7'h00, read_done_flag_q};
        serial_ext_pkg::OFS_EXT_READ_DATA_HIGH:       rdata_q <= read_word_upper_q;
        serial_ext_pkg::OFS_EXT_READ_DATA_LOW:        rdata_q <= read_word_lower_q;
        serial_ext_pkg::OFS_DEVICE_CONTROL:
          rdata_q <= {action_select_q, serial_output_override_out, 11'h000};
        default:                                      rdata_q <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  sequence write_launch_s;
    reg_wr_in && reg_addr_in == serial_ext_pkg::OFS_EXT_WRITE_CONTROL_STATUS &&
    reg_wdata_in[serial_ext_pkg::START_BIT] && !write_in_progress_flag_q;
  endsequence

  sequence read_launch_s;
    reg_wr_in && reg_addr_in == serial_ext_pkg::OFS_EXT_READ_CONTROL_STATUS &&
    reg_wdata_in[serial_ext_pkg::START_BIT] && !read_in_progress_flag_q;
  endsequence

  AST_WRITE_LAUNCH: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R3
    write_launch_s |=> write_in_progress_flag_q && !write_done_flag_q && mem_write_req_out)
    else $error("write start did not set busy and clear done");

  AST_WRITE_FINISH: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R4
    $fell(write_in_progress_flag_q) |-> write_done_flag_q)
    else $error("write ended without done flag");

  AST_READ_LAUNCH: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R6
    read_launch_s |=> read_in_progress_flag_q && !read_done_flag_q && mem_read_req_out)
    else $error("read start did not set busy and clear done");

  AST_READ_NVM_TIME: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R7
    read_launch_s ##0 (read_addr_q <= serial_ext_pkg::RD_NVM_HI)
    |=> read_in_progress_flag_q [*8] ##[1:500] read_done_flag_q)
    else $error("nonvolatile read finished too early or too late");

  AST_READ_RESULT: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R8
    $rose(read_done_flag_q) |-> {read_word_upper_q, read_word_lower_q} ==
    $past(mem_read_data_in))
    else $error("read result not captured at completion");

  AST_START_IGNORED: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R23
    reg_wr_in && reg_addr_in == serial_ext_pkg::OFS_EXT_WRITE_CONTROL_STATUS &&
    reg_wdata_in[serial_ext_pkg::START_BIT] && write_in_progress_flag_q && !write_expired
    |=> write_in_progress_flag_q && !mem_write_req_out)
    else $error("running write disturbed by a second start");

  AST_ACTION_DONE_DROP: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R22
    action_trigger |=> !action_done_flag_q && action_start_out)
    else $error("action done flag not dropped on trigger");

  AST_FIELD_CLEARS: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R9
    act_state_q == serial_ext_pkg::ACT_BUSY && action_complete_in
    |=> action_select_q == 4'h0 && action_done_flag_q)
    else $error("action field not zero after completion");

  AST_LOCKED_RELOAD: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R12
    wr_ctrl && !unlocked_in && new_code == serial_ext_pkg::ACT_NVM_RELOAD |-> !action_trigger)
    else $error("reload accepted while locked");

  AST_ERROR_CLEAR: assert property (@(posedge sys_clk_in) disable iff (reset_in) // R20
    wr_ctrl && reg_wdata_in[serial_ext_pkg::ERROR_CLR_BIT] |=> error_clear_out ##1
    (error_clear_out == $past(wr_ctrl && reg_wdata_in[serial_ext_pkg::ERROR_CLR_BIT])))
    else $error("error clear pulse missing");

endmodule

// ==== tb_serial_ext_regs.sv ====
// Self-checking bench for the extended access and device control bank
`timescale 1ns/1ps
module tb_serial_ext_regs;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, unl = 1'b0, boot = 1'b0;
  logic        rd_d = 1'b0, wreq, rreq, ast, acmp, mlo, mhi, ovr, adn, boot_done_flag, wclr, eclr;
  logic [7:0]  addr = 8'h00, wa, ra;
  logic [15:0] wdata = 16'h0000, rdata, hi, lo;
  logic [31:0] rdw, wd;
  logic [3:0]  acode;
  logic [15:0] exp_q [$];
  int          fail_count = 0, checked = 0;
  logic [3:0]  codes [11] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [7:0]  keys [11] = '{8'h46, 8'h46, 8'hA5, 8'h5A, 8'hB9, 8'hB9, 8'hB9, 8'h67,
                             8'h00, 8'h00, 8'h00};
  // Clock of 4 ns period
  always #2 clk = ~clk;
  serial_ext_regs #(.WRITE_CYCLES(20)) serial_ext_regs_i (.sys_clk_in(clk), .reset_in(rst),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .mem_write_req_out(wreq), .mem_write_addr_out(wa),
    .mem_write_data_out(wd), .mem_read_req_out(rreq), .mem_read_addr_out(ra),
    .mem_read_data_in(rdw), .unlocked_in(unl), .action_complete_in(acmp),
    .boot_complete_in(boot), .action_start_out(ast), .action_code_out(acode),
    .margin_low_out(mlo), .margin_high_out(mhi), .serial_output_override_out(ovr),
    .action_done_flag_out(adn), .boot_done_flag_out(boot_done_flag), .warning_clear_out(wclr),
    .error_clear_out(eclr));
  serial_ext_far_model serial_ext_far_model_i (.sys_clk_in(clk), .mem_write_req_in(wreq),
    .mem_write_addr_in(wa), .mem_write_data_in(wd), .mem_read_addr_in(ra),
    .mem_read_data_out(rdw), .action_start_in(ast), .action_complete_out(acmp));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic conclude();
    $display("fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Each read answer is compared with the oldest note
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d)
      chk(rdata, exp_q.pop_front());
  end
  // Watchdog against a hang
  initial begin
    #60000;
    fail_count++;
    conclude();
  end
  // Main sequence
  initial begin
    void'($urandom(45956));
    hi = $urandom;
    lo = $urandom;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rd_reg(8'h08, 16'h0000);
    wr_reg(8'h02, 16'hFF17);
    rd_reg(8'h02, 16'h0017);
    wr_reg(8'h04, hi);
    wr_reg(8'h06, lo);
    rd_reg(8'h04, hi);
    rd_reg(8'h06, lo);
    wr_reg(8'h08, 16'h8000);
    chk(wreq, 1'b1);
    wr_reg(8'h08, 16'h8000);
    chk(wreq, 1'b0);
    rd_reg(8'h08, 16'h0100);
    repeat (25) @(negedge clk);
    rd_reg(8'h08, 16'h0001);
    wr_reg(8'h0A, 16'h0017);
    wr_reg(8'h0C, 16'h8000);
    chk(rreq, 1'b1);
    rd_reg(8'h0C, 16'h0100);
    repeat (505) @(negedge clk);
    rd_reg(8'h0C, 16'h0001);
    rd_reg(8'h0E, hi);
    rd_reg(8'h10, lo);
    wr_reg(8'h1E, 16'h0800);
    rd_reg(8'h1E, 16'h0800);
    wr_reg(8'h1E, 16'h0300);
    chk({wclr, eclr, ovr}, 3'b110);
    rd_reg(8'h1E, 16'h0000);
    unl = 1'b1;
    foreach (codes[i]) begin
      wr_reg(8'h1E, {codes[i], 4'h0, keys[i]});
      chk({ast, adn, acode}, {2'b10, codes[i]});
      rd_reg(8'h1E, {codes[i], 12'h000});
      repeat (14) @(negedge clk);
      rd_reg(8'h1E, 16'h0000);
      chk(adn, 1'b1);
    end
    wr_reg(8'h1E, 16'h9046);
    chk(ast, 1'b0);
    unl = 1'b0;
    wr_reg(8'h1E, 16'h705A);
    chk(ast, 1'b0);
    wr_reg(8'h1E, 16'h1000);
    @(negedge clk);
    chk(mlo, 1'b0);
    unl = 1'b1;
    @(negedge clk);
    chk(mlo, 1'b1);
    wr_reg(8'h1E, 16'h2000);
    @(negedge clk);
    chk({mlo, mhi, ast}, 3'b010);
    rd_reg(8'h1E, 16'h2000);
    boot = 1'b1;
    @(negedge clk);
    boot = 1'b0;
    chk({adn, boot_done_flag}, 2'b11);
    wr_reg(8'h1E, 16'h0400);
    chk({adn, boot_done_flag}, 2'b00);
    repeat (3) @(negedge clk);
    conclude();
  end
endmodule
